// ==== inc/fcfl_pkg.sv ====
// fcfl_pkg: constants shared by the fault clear and failure log block
// assumes a 50 MHz core clock and a 16-bit serial register space
package fcfl_pkg;
	// ==========================================================
	// timing
	localparam int CLK_HZ       = 32'h02FA_F080;
	localparam int MS_PER_S     = 32'h0000_03E8;
	localparam int STOP_HOLD_MS = 32'h0000_07D0;
	localparam int SEC_PER_HOUR = 32'h0000_0E10;
	localparam int HOLD_CYCLES  = CLK_HZ / MS_PER_S * STOP_HOLD_MS;
	// ==========================================================
	// serial register numbers
	localparam logic [15:0] R_G0_FIRST  = 16'h9C40;
	localparam logic [15:0] R_G0_LAST   = 16'hA027;
	localparam logic [15:0] R_SPEED     = 16'h9C42;
	localparam logic [15:0] R_FREQ      = 16'h9C44;
	localparam logic [15:0] R_HOURS     = 16'h9C63;
	localparam logic [15:0] R_DI_LVL    = 16'h9C70;
	localparam logic [15:0] R_CTRL_MIR  = 16'h9C72;
	localparam logic [15:0] R_SPD_MIR   = 16'h9C74;
	localparam logic [15:0] R_LOOP_MIR  = 16'h9C75;
	localparam logic [15:0] R_MODE      = 16'hA03C;
	localparam logic [15:0] R_DI_SEL    = 16'hA83E;
	localparam logic [15:0] R_LOG_FIRST = 16'hA848;
	localparam logic [15:0] R_LOG_LAST  = 16'hA867;
	localparam logic [15:0] R_ACCESS    = 16'hABE2;
	localparam logic [15:0] R_RESTORE   = 16'hABE4;
	localparam logic [15:0] R_SER_EN    = 16'hABE7;
	localparam logic [15:0] R_SER_CTRL  = 16'h07D0;
	localparam logic [15:0] R_SER_SPD   = 16'h07D1;
	localparam logic [15:0] R_SER_LOOP  = 16'h07D2;
	// ==========================================================
	// values, limits and factory settings
	localparam logic [15:0] MODE_VECTOR = 16'h0003;
	localparam logic [15:0] MODE_UNUSED = 16'h0002;
	localparam logic [15:0] MODE_MAX    = 16'h0003;
	localparam logic [15:0] DI_SEL_MAX  = 16'h0006;
	localparam logic [15:0] FLAG_MAX    = 16'h0001;
	localparam logic [15:0] ACC_MAX     = 16'h0002;
	localparam logic [15:0] ACC_ELEV    = 16'h0002;
	localparam logic [15:0] RESTORE_CMD = 16'h0001;
	localparam logic [15:0] FACTORY_VAL = 16'h0000;
	localparam logic [7:0]  CNT_MAX     = 8'hFF;
	// ==========================================================
	// serial function and exception codes
	localparam logic [7:0] FN_READ   = 8'h03;
	localparam logic [7:0] FN_WRITE  = 8'h06;
	localparam logic [7:0] EXC_NONE  = 8'h00;
	localparam logic [7:0] EXC_FUNC  = 8'h01;
	localparam logic [7:0] EXC_ADDR  = 8'h02;
	localparam logic [7:0] EXC_VALUE = 8'h03;
endpackage : fcfl_pkg

// ==== logic/fcfl_fail_log.sv ====
// fcfl_fail_log: history of the most recent failures, newest at index 0
// assumes one-cycle failure events on the core clock
`timescale 1ns/1ps
module fcfl_fail_log #(
	parameter int DEPTH = 16
) (
	input  wire logic                     core_clk_i,
	input  wire logic                     srst_i,
	input  wire logic                     ev_i,
	input  wire logic [7:0]               code_i,
	input  wire logic [15:0]              hour_i,
	output logic      [2*DEPTH-1:0][15:0] words_o
);
	if (DEPTH < 2)
	begin : g_bad_depth
		$error("fcfl_fail_log: DEPTH below 2");
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (srst_i);

	logic [7:0]       code_q [DEPTH];
	logic [7:0]       cnt_q  [DEPTH];
	logic [15:0]      hour_q [DEPTH];
	logic [DEPTH-1:0] used_q;
	logic [7:0]       in_code [DEPTH];
	logic [7:0]       in_cnt  [DEPTH];
	logic [15:0]      in_hour [DEPTH];
	logic [DEPTH-1:0] in_used;
	logic [DEPTH-1:0] match;

	// ==========================================================
	// record slots
	for (genvar g = 0; g < DEPTH; g++)
	begin : g_rec
		if (g == 0)
		begin : g_head
			assign in_code[g] = code_i;
			assign in_cnt[g]  = 8'h01;
			assign in_hour[g] = hour_i;
			assign in_used[g] = 1'b1;
		end
		else
		begin : g_tail
			assign in_code[g] = code_q[g-1];
			assign in_cnt[g]  = cnt_q[g-1];
			assign in_hour[g] = hour_q[g-1];
			assign in_used[g] = used_q[g-1];
		end
		assign match[g] = used_q[g] && code_q[g] == code_i && hour_q[g] == hour_i;
		always_ff @(posedge core_clk_i)
		begin
			if (srst_i)
			begin
				code_q[g] <= 8'h00;
				cnt_q[g]  <= 8'h00;
				hour_q[g] <= 16'h0000;
				used_q[g] <= 1'b0;
			end
			else if (ev_i && |match)
			begin
				if (match[g] && cnt_q[g] != fcfl_pkg::CNT_MAX)
					cnt_q[g] <= cnt_q[g] + 8'h01;
			end
			else if (ev_i)
			begin
				code_q[g] <= in_code[g];
				cnt_q[g]  <= in_cnt[g];
				hour_q[g] <= in_hour[g];
				used_q[g] <= in_used[g];
			end
		end
		assign words_o[2*g]   = {cnt_q[g], code_q[g]};
		assign words_o[2*g+1] = hour_q[g];
	end

	a_log_shift: assert property (ev_i && !(|match) |=> code_q[0] == $past(code_i)
		&& code_q[DEPTH-1] == $past(code_q[DEPTH-2])) else $error("log did not shift");
	a_cnt_sat: assert property (ev_i && match[0] && cnt_q[0] == fcfl_pkg::CNT_MAX
		|=> cnt_q[0] == fcfl_pkg::CNT_MAX) else $error("occurrence count wrapped");
	a_cnt_inc: assert property (ev_i && match[0] && cnt_q[0] != fcfl_pkg::CNT_MAX
		|=> cnt_q[0] == $past(cnt_q[0]) + 8'h01) else $error("count not raised");
endmodule : fcfl_fail_log

// ==== logic/fcfl_top.sv ====
// fcfl_top: fault clearing, failure history and process variables
// assumes an Avalon-MM master on the core clock, a serial frame decoder
// on the core clock, and asynchronous stop key and digital input pins
//
// Design decisions made here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
module fcfl_top #(
	parameter int TICKS_PER_SEC = fcfl_pkg::CLK_HZ,
	parameter int HOLD_CYCLES   = fcfl_pkg::HOLD_CYCLES,
	parameter int SEC_PER_HOUR  = fcfl_pkg::SEC_PER_HOUR,
	parameter int LOG_DEPTH     = 16
) (
	input  wire logic        core_clk_i,
	input  wire logic        srst_i,
	input  wire logic [15:0] avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	input  wire logic        mb_req_valid_i,
	input  wire logic        mb_crc_ok_i,
	input  wire logic [7:0]  mb_func_i,
	input  wire logic [15:0] mb_addr_i,
	input  wire logic [15:0] mb_wdata_i,
	output logic             mb_rsp_valid_o,
	output logic      [7:0]  mb_rsp_exc_o,
	output logic      [15:0] mb_rsp_data_o,
	input  wire logic        stop_key_i,
	input  wire logic [5:0]  din_i,
	input  wire logic        fault_event_i,
	input  wire logic [7:0]  fault_code_i,
	input  wire logic        fault_cause_i,
	input  wire logic        start_req_i,
	input  wire logic        stop_req_i,
	input  wire logic [15:0] motor_speed_i,
	input  wire logic [15:0] out_freq_i,
	output logic             fault_o,
	output logic             drive_run_o,
	output logic             factory_restore_o
);
	if (TICKS_PER_SEC < 2 || HOLD_CYCLES < 1 || SEC_PER_HOUR < 2 || LOG_DEPTH != 16)
	begin : g_bad_param
		$error("fcfl_top: parameter out of range");
	end

	localparam int TW = $clog2(TICKS_PER_SEC);
	localparam int SW = $clog2(SEC_PER_HOUR);
	localparam int HW = $clog2(HOLD_CYCLES + 1);

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (srst_i);

	// ==========================================================
	// pin synchronisers
	logic [6:0] pin_m_q;
	logic [6:0] pin_s_q;
	logic       key_s;
	logic [5:0] din_s;

	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			pin_m_q <= 7'h00;
			pin_s_q <= 7'h00;
		end
		else
		begin
			pin_m_q <= {stop_key_i, din_i};
			pin_s_q <= pin_m_q;
		end
	end
	assign key_s = pin_s_q[6];
	assign din_s = pin_s_q[5:0];

	// ==========================================================
	// operating hours
	logic [TW-1:0] tick_q;
	logic [SW-1:0] sec_q;
	logic [15:0]   hours_q;

	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			tick_q  <= '0;
			sec_q   <= '0;
			hours_q <= 16'h0000;
		end
		else if (tick_q == TW'(TICKS_PER_SEC - 1))
		begin
			tick_q <= '0;
			if (sec_q == SW'(SEC_PER_HOUR - 1))
			begin
				sec_q   <= '0;
				hours_q <= hours_q + 16'h0001;
			end
			else
			begin
				sec_q <= sec_q + SW'(1);
			end
		end
		else
		begin
			tick_q <= tick_q + TW'(1);
		end
	end

	// ==========================================================
	// stop key hold timer
	logic [HW-1:0] hold_q;
	logic          hold_clr;

	assign hold_clr = key_s && hold_q == HW'(HOLD_CYCLES - 1);
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i || !key_s)
			hold_q <= '0;
		else if (hold_q != HW'(HOLD_CYCLES))
			hold_q <= hold_q + HW'(1);
	end

	// ==========================================================
	// parameter registers
	logic [15:0] di_sel_q;
	logic [15:0] ser_en_q;
	logic [15:0] acc_q;
	logic [15:0] mode_q;
	logic [15:0] ser_ctrl_q;
	logic [15:0] ser_spd_q;
	logic [15:0] ser_loop_q;
	logic [2*LOG_DEPTH-1:0][15:0] log_words;
	logic        av_we;
	logic        mb_we;
	logic        restore_go;
	logic        restore_q;

	function automatic logic [16:0] rd_param(input logic [15:0] a);
		logic [16:0] r;
		logic [15:0] off;
		r   = {1'b1, 16'h0000};
		off = a - fcfl_pkg::R_LOG_FIRST;
		if (a == fcfl_pkg::R_SPEED)
			r[15:0] = (mode_q == fcfl_pkg::MODE_VECTOR) ? motor_speed_i : 16'h0000;
		else if (a == fcfl_pkg::R_FREQ)
			r[15:0] = (mode_q != fcfl_pkg::MODE_VECTOR) ? out_freq_i : 16'h0000;
		else if (a == fcfl_pkg::R_HOURS)
			r[15:0] = hours_q;
		else if (a == fcfl_pkg::R_DI_LVL)
			r[15:0] = {10'h000, din_s};
		else if (a == fcfl_pkg::R_CTRL_MIR || a == fcfl_pkg::R_SER_CTRL)
			r[15:0] = ser_ctrl_q;
		else if (a == fcfl_pkg::R_SPD_MIR || a == fcfl_pkg::R_SER_SPD)
			r[15:0] = ser_spd_q;
		else if (a == fcfl_pkg::R_LOOP_MIR || a == fcfl_pkg::R_SER_LOOP)
			r[15:0] = ser_loop_q;
		else if (a == fcfl_pkg::R_MODE)
			r[15:0] = mode_q;
		else if (a == fcfl_pkg::R_DI_SEL)
			r[15:0] = di_sel_q;
		else if (a >= fcfl_pkg::R_LOG_FIRST && a <= fcfl_pkg::R_LOG_LAST)
			r[15:0] = log_words[off[4:0]];
		else if (a == fcfl_pkg::R_ACCESS)
			r[15:0] = acc_q;
		else if (a == fcfl_pkg::R_RESTORE)
			r[15:0] = 16'h0000;
		else if (a == fcfl_pkg::R_SER_EN)
			r[15:0] = ser_en_q;
		else
			r = 17'h00000;
		return r;
	endfunction : rd_param

	function automatic logic [7:0] wr_exc(input logic [15:0] a, input logic [15:0] d);
		logic [7:0] e;
		e = fcfl_pkg::EXC_NONE;
		if (a >= fcfl_pkg::R_G0_FIRST && a <= fcfl_pkg::R_G0_LAST)
			e = fcfl_pkg::EXC_ADDR;
		else if (a == fcfl_pkg::R_MODE)
		begin
			if (d > fcfl_pkg::MODE_MAX || d == fcfl_pkg::MODE_UNUSED)
				e = fcfl_pkg::EXC_VALUE;
		end
		else if (a == fcfl_pkg::R_DI_SEL)
		begin
			if (d > fcfl_pkg::DI_SEL_MAX)
				e = fcfl_pkg::EXC_VALUE;
		end
		else if (a == fcfl_pkg::R_ACCESS)
		begin
			if (d > fcfl_pkg::ACC_MAX)
				e = fcfl_pkg::EXC_VALUE;
		end
		else if (a == fcfl_pkg::R_RESTORE || a == fcfl_pkg::R_SER_EN)
		begin
			if (d > fcfl_pkg::FLAG_MAX)
				e = fcfl_pkg::EXC_VALUE;
		end
		else if (a != fcfl_pkg::R_SER_CTRL && a != fcfl_pkg::R_SER_SPD
			&& a != fcfl_pkg::R_SER_LOOP)
			e = fcfl_pkg::EXC_ADDR;
		return e;
	endfunction : wr_exc

	// serial write wins when both masters hit one register
	function automatic logic [15:0] upd(input logic [15:0] old, input logic [15:0] a,
		input logic [15:0] av_d);
		logic [15:0] v;
		v = old;
		if (av_we && avs_address_i == a)
			v = av_d;
		if (mb_we && mb_addr_i == a)
			v = mb_wdata_i;
		return v;
	endfunction : upd

	assign restore_go = acc_q == fcfl_pkg::ACC_ELEV &&
		((av_we && avs_address_i == fcfl_pkg::R_RESTORE
		&& avs_writedata_i[15:0] == fcfl_pkg::RESTORE_CMD)
		|| (mb_we && mb_addr_i == fcfl_pkg::R_RESTORE
		&& mb_wdata_i == fcfl_pkg::RESTORE_CMD));

	always_ff @(posedge core_clk_i)
	begin
		if (srst_i || restore_go)
		begin
			di_sel_q <= fcfl_pkg::FACTORY_VAL;
			ser_en_q <= fcfl_pkg::FACTORY_VAL;
			acc_q    <= fcfl_pkg::FACTORY_VAL;
			mode_q   <= fcfl_pkg::FACTORY_VAL;
		end
		else
		begin
			di_sel_q <= upd(di_sel_q, fcfl_pkg::R_DI_SEL, avs_writedata_i[15:0]);
			ser_en_q <= upd(ser_en_q, fcfl_pkg::R_SER_EN, avs_writedata_i[15:0]);
			acc_q    <= upd(acc_q, fcfl_pkg::R_ACCESS, avs_writedata_i[15:0]);
			mode_q   <= upd(mode_q, fcfl_pkg::R_MODE, avs_writedata_i[15:0]);
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			ser_ctrl_q <= 16'h0000;
			ser_spd_q  <= 16'h0000;
			ser_loop_q <= 16'h0000;
			restore_q  <= 1'b0;
		end
		else
		begin
			ser_ctrl_q <= upd(ser_ctrl_q, fcfl_pkg::R_SER_CTRL, avs_writedata_i[15:0]);
			ser_spd_q  <= upd(ser_spd_q, fcfl_pkg::R_SER_SPD, avs_writedata_i[15:0]);
			ser_loop_q <= upd(ser_loop_q, fcfl_pkg::R_SER_LOOP, avs_writedata_i[15:0]);
			restore_q  <= restore_go;
		end
	end

	// ==========================================================
	// Avalon-MM slave
	logic [16:0] av_rd;
	logic        wait_q;
	logic [31:0] rdata_q;

	// process form so live state read by the function is watched
	always_comb
		av_rd = rd_param(avs_address_i);
	assign av_we = avs_write_i && !wait_q && (&avs_byteenable_i[1:0])
		&& wr_exc(avs_address_i, avs_writedata_i[15:0]) == fcfl_pkg::EXC_NONE;

	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			wait_q  <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end
		else if ((avs_read_i || avs_write_i) && wait_q)
		begin
			wait_q  <= 1'b0;
			rdata_q <= {16'h0000, av_rd[15:0]};
		end
		else
		begin
			wait_q <= 1'b1;
		end
	end

	// ==========================================================
	// serial request handling
	logic [16:0] mb_rd;
	logic [7:0]  mb_wexc;
	logic [7:0]  mb_exc;
	logic        mb_ok;
	logic        rsp_valid_q;
	logic [7:0]  rsp_exc_q;
	logic [15:0] rsp_data_q;

	assign mb_ok   = mb_req_valid_i && mb_crc_ok_i;
	always_comb
		mb_rd = rd_param(mb_addr_i);
	assign mb_wexc = wr_exc(mb_addr_i, mb_wdata_i);
	assign mb_we   = mb_ok && mb_func_i == fcfl_pkg::FN_WRITE
		&& mb_wexc == fcfl_pkg::EXC_NONE;

	always_comb
	begin
		if (mb_func_i == fcfl_pkg::FN_READ)
			mb_exc = mb_rd[16] ? fcfl_pkg::EXC_NONE : fcfl_pkg::EXC_ADDR;
		else if (mb_func_i == fcfl_pkg::FN_WRITE)
			mb_exc = mb_wexc;
		else
			mb_exc = fcfl_pkg::EXC_FUNC;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			rsp_valid_q <= 1'b0;
			rsp_exc_q   <= fcfl_pkg::EXC_NONE;
			rsp_data_q  <= 16'h0000;
		end
		else
		begin
			rsp_valid_q <= mb_ok;
			if (mb_ok)
			begin
				rsp_exc_q  <= mb_exc;
				rsp_data_q <= (mb_func_i == fcfl_pkg::FN_WRITE) ? mb_wdata_i : mb_rd[15:0];
			end
		end
	end

	// ==========================================================
	// fault state and drive permit
	logic ser_hit;
	logic ser_arm_q;
	logic ser_clr;
	logic di_clr;
	logic fault_q;
	logic run_q;

	assign ser_hit = mb_we && mb_addr_i == fcfl_pkg::R_SER_CTRL && ser_en_q[0];
	assign ser_clr = ser_hit && ser_arm_q;
	assign di_clr  = di_sel_q != 16'h0000 && di_sel_q <= fcfl_pkg::DI_SEL_MAX
		&& din_s[3'(di_sel_q[2:0] - 3'h1)];

	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
			ser_arm_q <= 1'b0;
		else if (mb_ok)
			ser_arm_q <= ser_hit && !ser_arm_q;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
			fault_q <= 1'b0;
		else if (fault_event_i)
			fault_q <= 1'b1;
		else if (hold_clr || di_clr || ser_clr)
			fault_q <= 1'b0;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
			run_q <= 1'b0;
		else if (fault_event_i || fault_q || stop_req_i || key_s)
			run_q <= 1'b0;
		else if (start_req_i && !fault_cause_i)
			run_q <= 1'b1;
	end

	fcfl_fail_log #(
		.DEPTH (LOG_DEPTH)
	) u_log (
		.core_clk_i (core_clk_i),
		.srst_i     (srst_i),
		.ev_i       (fault_event_i),
		.code_i     (fault_code_i),
		.hour_i     (hours_q),
		.words_o    (log_words)
	);

	assign avs_readdata_o    = rdata_q;
	assign avs_waitrequest_o = wait_q;
	assign mb_rsp_valid_o    = rsp_valid_q;
	assign mb_rsp_exc_o      = rsp_exc_q;
	assign mb_rsp_data_o     = rsp_data_q;
	assign fault_o           = fault_q;
	assign drive_run_o       = run_q;
	assign factory_restore_o = restore_q;

	// ==========================================================
	// checks
	a_fault_stop: assert property (fault_event_i |=> fault_q && !run_q)
		else $error("fault did not stop the drive");
	a_hold_clear: assert property (hold_clr && !fault_event_i |=> !fault_q)
		else $error("long stop press did not clear");
	a_short_press: assert property (fault_q && !key_s && !di_clr && !ser_clr |=> fault_q)
		else $error("fault cleared without a cause");
	a_crc_silent: assert property (mb_req_valid_i && !mb_crc_ok_i |=> !mb_rsp_valid_o)
		else $error("answer sent to corrupted frame");
	a_bad_func: assert property (mb_ok && mb_func_i != fcfl_pkg::FN_READ
		&& mb_func_i != fcfl_pkg::FN_WRITE |=> mb_rsp_exc_o == fcfl_pkg::EXC_FUNC)
		else $error("unknown function not refused");
	a_ro_write: assert property (mb_ok && mb_func_i == fcfl_pkg::FN_WRITE
		&& mb_addr_i == fcfl_pkg::R_CTRL_MIR |=> mb_rsp_exc_o == fcfl_pkg::EXC_ADDR
		&& $stable(ser_ctrl_q)) else $error("read-only variable written");
	a_mirror_upd: assert property (mb_we && mb_addr_i == fcfl_pkg::R_SER_CTRL
		|=> ser_ctrl_q == $past(mb_wdata_i)) else $error("mirror not updated");
	a_double_clr: assert property (ser_clr && !fault_event_i |=> !fault_q)
		else $error("double serial write did not clear");
	a_restore_gate: assert property (factory_restore_o |-> $past(acc_q) == fcfl_pkg::ACC_ELEV)
		else $error("restore without access");
	a_di_levels: assert property (avs_read_i && wait_q
		&& avs_address_i == fcfl_pkg::R_DI_LVL |=> avs_readdata_o[31:6] == 26'h0)
		else $error("input level word has high bits");
endmodule : fcfl_top

// ==== verif/fcfl_mb_master.sv ====
// fcfl_mb_master: serial master model driving decoded requests into the block
// assumes the block answers exactly one clock after a good request
`timescale 1ns/1ps
module fcfl_mb_master (
	input  wire logic        core_clk_i,
	input  wire logic        mb_rsp_valid_i,
	input  wire logic [7:0]  mb_rsp_exc_i,
	input  wire logic [15:0] mb_rsp_data_i,
	output logic             mb_req_valid_o,
	output logic             mb_crc_ok_o,
	output logic      [7:0]  mb_func_o,
	output logic      [15:0] mb_addr_o,
	output logic      [15:0] mb_wdata_o
);
	initial
	begin
		mb_req_valid_o = 1'b0;
		mb_crc_ok_o    = 1'b0;
		mb_func_o      = 8'h00;
		mb_addr_o      = 16'h0000;
		mb_wdata_o     = 16'h0000;
	end
	// ==========================================================
	// one request per call, released fields show their inverse
	task automatic send(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
		input logic ok, output logic [7:0] exc, output logic [15:0] rd, output logic seen);
		@(posedge core_clk_i);
		mb_req_valid_o <= 1'b1;
		mb_crc_ok_o    <= ok;
		mb_func_o      <= f;
		mb_addr_o      <= a;
		mb_wdata_o     <= d;
		@(posedge core_clk_i);
		mb_req_valid_o <= 1'b0;
		mb_crc_ok_o    <= ~ok;
		mb_func_o      <= ~f;
		mb_addr_o      <= ~a;
		mb_wdata_o     <= ~d;
		@(posedge core_clk_i);
		seen = mb_rsp_valid_i;
		exc  = mb_rsp_exc_i;
		rd   = mb_rsp_data_i;
	endtask : send
endmodule : fcfl_mb_master

// ==== verif/fcfl_top_bench.sv ====
// fcfl_top_bench: self-checking bench of the fault clear and failure log block
// assumes fcfl_mb_master as serial partner; the bench drives bus and pins
`timescale 1ns/1ps
module fcfl_top_bench;
	// ==========================================================
	// signals
	localparam int HOLD = 20;
	localparam logic [7:0] WR = fcfl_pkg::FN_WRITE;
	localparam logic [7:0] RD = fcfl_pkg::FN_READ;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic [15:0] a_q = 16'h0000;
	logic        rd_q = 1'b0;
	logic        wr_q = 1'b0;
	logic [31:0] wd_q = 32'h0000_0000;
	logic        key = 1'b0;
	logic [5:0]  din = 6'h00;
	logic        fev = 1'b0;
	logic [7:0]  fcode = 8'h00;
	logic        cause = 1'b0;
	logic        st = 1'b0;
	logic        sp = 1'b0;
	logic [15:0] spd = 16'h0000;
	logic [15:0] frq = 16'h0000;
	logic [31:0] rdat, v;
	logic        wreq, rq, crc, rv, fault, run, rest, s_seen;
	logic [7:0]  fn, exc, s_exc;
	logic [15:0] ad, wd, rdata, s_rd, h;
	int          error_cnt = 0;
	int          compares = 0;
	int          seed = 31;
	int          rest_cnt = 0;
	int          i, m, n;
	always #10 clk = ~clk;
	always @(posedge clk) if (rest === 1'b1) rest_cnt <= rest_cnt + 1;
	fcfl_top #(
		.TICKS_PER_SEC(10),
		.HOLD_CYCLES  (HOLD),
		.SEC_PER_HOUR (100),
		.LOG_DEPTH    (16)
	) fcfl_top_i (
		.core_clk_i       (clk),
		.srst_i           (srst),
		.avs_address_i    (a_q),
		.avs_read_i       (rd_q),
		.avs_write_i      (wr_q),
		.avs_writedata_i  (wd_q),
		.avs_byteenable_i (4'hF),
		.avs_readdata_o   (rdat),
		.avs_waitrequest_o(wreq),
		.mb_req_valid_i   (rq),
		.mb_crc_ok_i      (crc),
		.mb_func_i        (fn),
		.mb_addr_i        (ad),
		.mb_wdata_i       (wd),
		.mb_rsp_valid_o   (rv),
		.mb_rsp_exc_o     (exc),
		.mb_rsp_data_o    (rdata),
		.stop_key_i       (key),
		.din_i            (din),
		.fault_event_i    (fev),
		.fault_code_i     (fcode),
		.fault_cause_i    (cause),
		.start_req_i      (st),
		.stop_req_i       (sp),
		.motor_speed_i    (spd),
		.out_freq_i       (frq),
		.fault_o          (fault),
		.drive_run_o      (run),
		.factory_restore_o(rest)
	);
	fcfl_mb_master fcfl_mb_master_i (
		.core_clk_i    (clk),
		.mb_rsp_valid_i(rv),
		.mb_rsp_exc_i  (exc),
		.mb_rsp_data_i (rdata),
		.mb_req_valid_o(rq),
		.mb_crc_ok_o   (crc),
		.mb_func_o     (fn),
		.mb_addr_o     (ad),
		.mb_wdata_o    (wd)
	);
	// ==========================================================
	// helpers
	function automatic logic [15:0] pn(input int g, input int nn);
		return 16'(32'h0000_9C40 + 32'h0000_03E8 * g + nn);
	endfunction : pn
	task automatic give_verdict();
		if (error_cnt == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
	endtask : tick
	task automatic av(input logic w, input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		a_q  <= a;
		wd_q <= {16'h0000, d};
		wr_q <= w;
		rd_q <= ~w;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (wreq !== 1'b0 && n < 50);
		v = rdat;
		rd_q <= 1'b0;
		wr_q <= 1'b0;
		chk(32'(n < 50), 32'h1);
	endtask : av
	task automatic rdc(input logic [15:0] a, input logic [31:0] e);
		av(1'b0, a, 16'h0000);
		chk(v, e);
	endtask : rdc
	task automatic ser(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
		input logic ok);
		fcfl_mb_master_i.send(f, a, d, ok, s_exc, s_rd, s_seen);
		chk(32'(s_seen), 32'(ok));
	endtask : ser
	task automatic flt(input logic [7:0] c);
		@(posedge clk);
		fev   <= 1'b1;
		fcode <= c;
		@(posedge clk);
		fev <= 1'b0;
	endtask : flt
	task automatic go();
		@(posedge clk);
		st <= 1'b1;
		@(posedge clk);
		st <= 1'b0;
		tick(2);
	endtask : go
	initial
	begin
		tick(20000);
		error_cnt++;
		give_verdict();
	end
	// ==========================================================
	// scenarios
	initial
	begin
		tick(8);
		srst <= 1'b0;
		tick(1);
		chk(32'(fault), 32'h0);
		rdc(pn(3, 80), 32'h0);
		for (i = 0; i < 3; i++)
		begin
			v = $random(seed);
			h = v[15:0];
			m = (i == 0) ? 50 : 51 + i;
			ser(WR, 16'h07D0 + 16'(i), h, 1'b1);
			rdc(pn(0, m), 32'(h));
			ser(WR, pn(0, m), ~h, 1'b1);
			chk(32'(s_exc), 32'h2);
			rdc(pn(0, m), 32'(h));
		end
		ser(WR, 16'h07D2, ~h, 1'b0);
		rdc(pn(0, 53), 32'(h));
		v = $random(seed);
		ser(v[7:0] | 8'h10, pn(1, 20), 16'h0000, 1'b1);
		chk(32'(s_exc), 32'h1);
		ser(RD, 16'h0001, 16'h0000, 1'b1);
		chk(32'(s_exc), 32'h2);
		ser(WR, pn(1, 20), 16'h0002, 1'b1);
		chk(32'(s_exc), 32'h3);
		v = $random(seed);
		din <= v[5:0];
		spd <= v[31:16];
		frq <= v[15:0];
		tick(4);
		ser(RD, pn(0, 48), 16'h0000, 1'b1);
		chk(32'(s_rd), 32'(din));
		rdc(pn(0, 48), 32'(din));
		for (i = 0; i < 4; i++)
			if (i != 2)
			begin
				av(1'b1, pn(1, 20), 16'(i));
				rdc(pn(0, 2), (i == 3) ? 32'(spd) : 32'h0);
				rdc(pn(0, 4), (i == 3) ? 32'h0 : 32'(frq));
			end
		din <= 6'h00;
		cause <= 1'b1;
		flt(8'h01);
		tick(1);
		chk(32'(fault), 32'h1);
		key <= 1'b1;
		tick(HOLD - 2);
		key <= 1'b0;
		tick(6);
		chk(32'(fault), 32'h1);
		go();
		chk(32'(run), 32'h0);
		key <= 1'b1;
		m = 0;
		while (fault !== 1'b0 && m < 60)
		begin
			tick(1);
			m++;
		end
		chk(32'(m >= HOLD && m <= HOLD + 5), 32'h1);
		key <= 1'b0;
		tick(3);
		go();
		chk(32'(run), 32'h0);
		cause <= 1'b0;
		go();
		chk(32'(run), 32'h1);
		sp <= 1'b1;
		tick(1);
		sp <= 1'b0;
		tick(2);
		chk(32'(run), 32'h0);
		go();
		chk(32'(run), 32'h1);
		flt(8'h01);
		tick(1);
		chk(32'(run), 32'h0);
		for (i = 1; i < 7; i++)
		begin
			av(1'b1, pn(3, 70), 16'(i));
			flt(8'h01);
			din <= ~(6'h01 << (i - 1));
			tick(6);
			chk(32'(fault), 32'h1);
			din <= 6'h01 << (i - 1);
			tick(6);
			chk(32'(fault), 32'h0);
			din <= 6'h00;
			tick(4);
		end
		flt(8'h01);
		ser(WR, 16'h07D0, 16'h0000, 1'b1);
		ser(WR, 16'h07D0, 16'h0000, 1'b1);
		tick(2);
		chk(32'(fault), 32'h1);
		av(1'b1, pn(4, 7), 16'h0001);
		ser(WR, 16'h07D0, 16'h0000, 1'b1);
		ser(RD, 16'h07D1, 16'h0000, 1'b1);
		ser(WR, 16'h07D0, 16'h0000, 1'b1);
		tick(2);
		chk(32'(fault), 32'h1);
		ser(WR, 16'h07D0, 16'h0000, 1'b1);
		tick(2);
		chk(32'(fault), 32'h0);
		av(1'b1, pn(3, 70), 16'h0003);
		av(1'b1, pn(4, 4), 16'h0001);
		tick(2);
		chk(32'(rest_cnt), 32'h0);
		rdc(pn(3, 70), 32'h3);
		av(1'b1, pn(4, 2), 16'h0002);
		av(1'b1, pn(4, 4), 16'h0001);
		tick(2);
		chk(32'(rest_cnt), 32'h1);
		rdc(pn(4, 7), 32'h0);
		rdc(pn(3, 70), 32'h0);
		ser(RD, pn(0, 35), 16'h0000, 1'b1);
		h = s_rd;
		m = 0;
		while (s_rd === h && m < 500)
		begin
			ser(RD, pn(0, 35), 16'h0000, 1'b1);
			m++;
		end
		chk(32'(s_rd), 32'(h + 16'h0001));
		h = s_rd;
		for (i = 0; i < 300; i++)
			flt(8'h55);
		rdc(pn(3, 80), 32'h0000_FF55);
		rdc(pn(3, 81), 32'(h));
		for (i = 1; i < 17; i++)
			flt(8'h80 + 8'(i));
		flt(8'h90);
		tick(1);
		rdc(pn(3, 80), 32'h0000_0290);
		rdc(pn(3, 82), 32'h0000_018F);
		rdc(pn(3, 110), 32'h0000_0181);
		rdc(pn(3, 111), 32'(h));
		give_verdict();
	end
endmodule : fcfl_top_bench
